// [design/apph_contact.sv]
`timescale 1ns/1ps
module apph_contact #(
    parameter logic CLOSED_AT_RESET = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic active,
    output logic closed
);
    // Relay drive: an active signal opens the contact, so a broken wire reads as active
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            closed <= CLOSED_AT_RESET;
        end else begin
            closed <= ~active;
        end
    end

    contact_open_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        active |=> !closed)
        else $error("active signal did not open the contact");

endmodule

// [design/apph_debounce.sv]
`timescale 1ns/1ps
module apph_debounce #(
    parameter int CYCLES = apph_pkg::APPH_DEBOUNCE_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic raw,
    output logic level,
    output logic rise
);
    import apph_pkg::*;

    localparam logic [APPH_DB_W-1:0] CNT_MAX = APPH_DB_W'(CYCLES - 1);

    logic sync1_reg, sync2_reg, level_reg, rise_reg;
    logic [APPH_DB_W-1:0] cnt_reg;
    wire differs = sync2_reg != level_reg;
    wire settled = differs && (cnt_reg == CNT_MAX);

    // Two flops, then a level must differ for CYCLES clocks to be accepted
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            cnt_reg <= '0;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
            cnt_reg <= (differs && !settled) ? cnt_reg + 1'b1 : '0;
            level_reg <= settled ? sync2_reg : level_reg;
            rise_reg <= settled && sync2_reg;
        end
    end

    assign level = level_reg;
    assign rise = rise_reg;

    db_settle_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $changed(level_reg) |-> $past(cnt_reg) == CNT_MAX && $past(sync2_reg) == level_reg)
        else $error("debounced level changed before settling");

endmodule

// [design/apph_pkg.sv]
// How it works
// - A rising start request launches one labelling cycle.
// - A stop lets the label being printed finish and reach the pad.
// - A stop aborts a running application or blocks one not yet begun.
// - A stop sends the pad back to its starting position.
// - Once stopped, every later start request is ignored until re-armed.
// - Stop while applying flags a host-stop error; stop while printing does not.
// - First-label request prints ahead only in apply-after-print mode.
// - Printer error shows on its output; after clearing, the label is reprinted.
// - Job-absent output stays active while no print job is available.
// - Printer-fault contact opens when active; closed means inactive.
// - All contacts share one common return; the controller senses against it.
// - Inverted pad-home output is always the complement of pad-home.
// - Pad-down output shows labelling position; applicator fault has its own.
// - General fault is active when printer or applicator fault is active.
// - Pad-home output is active while the pad sits in starting position.
package apph_pkg;

    // Clock and input filter timing
    localparam int APPH_CLK_HZ = 20_000_000;
    localparam int APPH_DEBOUNCE_US = 5;
    localparam int APPH_DEBOUNCE_CYC = (APPH_DEBOUNCE_US * APPH_CLK_HZ + 999_999) / 1_000_000;
    localparam int APPH_DB_W = 8;

    // Register word indices on the bus
    localparam int APPH_ADDR_W = 3;
    localparam logic [2:0] APPH_CTRL_IDX = 3'h0;
    localparam logic [2:0] APPH_STATUS_IDX = 3'h1;
    localparam logic [2:0] APPH_IRQ_STAT_IDX = 3'h2;
    localparam logic [2:0] APPH_IRQ_CLR_IDX = 3'h3;
    localparam logic [2:0] APPH_IRQ_EN_IDX = 3'h4;

    // Control register fields and reset values
    localparam int APPH_CTRL_MODE_BIT = 0;
    localparam int APPH_CTRL_REARM_BIT = 1;
    localparam logic APPH_CTRL_MODE_RST = 1'b0;

    // Interrupt event bits
    localparam int APPH_EV_W = 5;
    localparam int APPH_EV_START = 0;
    localparam int APPH_EV_STOP = 1;
    localparam int APPH_EV_HOST_ERR = 2;
    localparam int APPH_EV_PRN_FAULT = 3;
    localparam int APPH_EV_DONE = 4;
    localparam logic [4:0] APPH_IRQ_EN_RST = 5'h00;

    // Labelling sequencer states, Gray in the order IDLE, PRINT, HOLD, LOWER, RAISE
    typedef enum logic [2:0] {
        APPH_ST_IDLE = 3'h0,
        APPH_ST_PRINT = 3'h1,
        APPH_ST_HOLD = 3'h3,
        APPH_ST_LOWER = 3'h2,
        APPH_ST_RAISE = 3'h6,
        APPH_ST_FAULT = 3'h5
    } apph_state_e;

endpackage

// [design/apph_top.sv]
`timescale 1ns/1ps
module apph_top (
    input wire logic ref_clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [apph_pkg::APPH_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // Isolated controller inputs, high while voltage is applied
    input wire logic start_request_in,
    input wire logic stop_request_in,
    input wire logic first_label_request_in,
    // Printer and applicator status
    input wire logic printer_error_in,
    input wire logic job_available_in,
    input wire logic label_picked_in,
    input wire logic pad_at_home_in,
    input wire logic pad_at_label_in,
    input wire logic applicator_error_in,
    // Mechanism commands
    output logic print_cmd_out,
    output logic pad_lower_out,
    // Contact drives toward the controller, high while the contact is closed
    output logic printer_fault_out,
    output logic job_absent_out,
    output logic any_fault_out,
    output logic pad_home_out,
    output logic pad_home_n_out,
    output logic pad_down_out,
    output logic applicator_fault_out
);
    import apph_pkg::*;

    wire start_db, start_rise, stop_db, first_db, first_rise;
    apph_state_e state_reg, state_next;
    logic stop_latched_reg, host_err_reg, pending_reg, ack_reg;
    logic print_cmd_reg, pad_lower_reg, mode_reg;
    logic [APPH_EV_W-1:0] irq_stat_reg, irq_en_reg;
    logic [31:0] rdata_reg;

    // Input conditioning; the return lines are the far ends of each isolated pair
    apph_debounce u_start_db (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .raw(start_request_in),
        .level(start_db),
        .rise(start_rise)
    );
    apph_debounce u_stop_db (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .raw(stop_request_in),
        .level(stop_db),
        .rise()
    );
    apph_debounce u_first_db (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .raw(first_label_request_in),
        .level(first_db),
        .rise(first_rise)
    );

    // Bus decode; every access waits one cycle so read data come from a flop
    wire access = avs_read | avs_write;
    wire wr_fire = avs_write && ack_reg && avs_byteenable[0];
    wire rd_load = avs_read && !ack_reg;
    wire wr_ctrl = wr_fire && (avs_address == APPH_CTRL_IDX);
    wire wr_clr = wr_fire && (avs_address == APPH_IRQ_CLR_IDX);
    wire wr_en = wr_fire && (avs_address == APPH_IRQ_EN_IDX);
    wire rearm = wr_ctrl && avs_writedata[APPH_CTRL_REARM_BIT];
    wire [APPH_EV_W-1:0] clr_mask = wr_clr ? avs_writedata[APPH_EV_W-1:0] : '0;
    assign avs_waitrequest = access && !ack_reg;

    // Read selection; write-only and unmapped words read as zero
    wire [31:0] status_word = {23'h000000, pending_reg, first_db, stop_db, start_db,
                               host_err_reg, stop_latched_reg, state_reg};
    wire [31:0] rd_mux =
        (avs_address == APPH_CTRL_IDX) ? {31'h00000000, mode_reg} :
        (avs_address == APPH_STATUS_IDX) ? status_word :
        (avs_address == APPH_IRQ_STAT_IDX) ? {27'h0000000, irq_stat_reg} :
        (avs_address == APPH_IRQ_EN_IDX) ? {27'h0000000, irq_en_reg} : 32'h00000000;

    // Request qualification: a latched or present stop blocks new work
    wire blocked = stop_latched_reg || stop_db;
    wire go_start = start_rise && !blocked;
    wire go_first = first_rise && mode_reg && !blocked;
    wire new_stop = stop_db && !stop_latched_reg;

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            APPH_ST_IDLE: begin
                if (go_start || go_first) begin
                    state_next = APPH_ST_PRINT;
                end
            end
            APPH_ST_PRINT: begin
                if (printer_error_in) begin
                    state_next = APPH_ST_FAULT;
                end else if (label_picked_in) begin
                    // The label in flight is finished before a stop halts us
                    if (blocked) begin
                        state_next = APPH_ST_IDLE;
                    end else if (pending_reg || go_start) begin
                        state_next = APPH_ST_LOWER;
                    end else begin
                        state_next = APPH_ST_HOLD;
                    end
                end
            end
            APPH_ST_HOLD: begin
                if (go_start) begin
                    state_next = APPH_ST_LOWER;
                end
            end
            APPH_ST_LOWER: begin
                if (blocked || pad_at_label_in) begin
                    state_next = APPH_ST_RAISE;
                end
            end
            APPH_ST_RAISE: begin
                if (pad_at_home_in) begin
                    // Apply-after-print prepares the next label at once
                    if (mode_reg && !blocked) begin
                        state_next = APPH_ST_PRINT;
                    end else begin
                        state_next = APPH_ST_IDLE;
                    end
                end
            end
            APPH_ST_FAULT: begin
                if (!printer_error_in) begin
                    state_next = APPH_ST_PRINT;
                end
            end
            default: begin
                state_next = APPH_ST_IDLE;
            end
        endcase
    end

    // Events feeding the sticky status
    wire enter_print = (state_next == APPH_ST_PRINT) && (state_reg != APPH_ST_PRINT);
    wire host_err_set = new_stop && (state_reg == APPH_ST_LOWER);
    wire [APPH_EV_W-1:0] events;
    assign events[APPH_EV_START] = go_start;
    assign events[APPH_EV_STOP] = new_stop;
    assign events[APPH_EV_HOST_ERR] = host_err_set;
    assign events[APPH_EV_PRN_FAULT] = (state_next == APPH_ST_FAULT) &&
                                       (state_reg != APPH_ST_FAULT);
    assign events[APPH_EV_DONE] = (state_reg == APPH_ST_RAISE) && pad_at_home_in;

    // Sequencer and command registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= APPH_ST_IDLE;
            print_cmd_reg <= 1'b0;
            pad_lower_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            print_cmd_reg <= enter_print;
            pad_lower_reg <= state_next == APPH_ST_LOWER;
        end
    end

    // Stop latch and host-stop flag; a stop in the rearm cycle wins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stop_latched_reg <= 1'b0;
            host_err_reg <= 1'b0;
        end else begin
            stop_latched_reg <= stop_db || (stop_latched_reg && !rearm);
            host_err_reg <= host_err_set || (host_err_reg && !rearm);
        end
    end

    // A start seen before the label is on the pad is remembered for application
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pending_reg <= 1'b0;
        end else if (state_next == APPH_ST_LOWER || blocked) begin
            pending_reg <= 1'b0;
        end else if (go_start) begin
            pending_reg <= 1'b1;
        end
    end

    // Bus slave registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            mode_reg <= APPH_CTRL_MODE_RST;
            irq_en_reg <= APPH_IRQ_EN_RST;
        end else begin
            ack_reg <= access && !ack_reg;
            rdata_reg <= rd_load ? rd_mux : rdata_reg;
            mode_reg <= wr_ctrl ? avs_writedata[APPH_CTRL_MODE_BIT] : mode_reg;
            irq_en_reg <= wr_en ? avs_writedata[APPH_EV_W-1:0] : irq_en_reg;
        end
    end

    // Sticky interrupt status; an event in the clearing cycle survives
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~clr_mask) | events;
        end
    end

    assign avs_readdata = rdata_reg;
    assign irq = |(irq_stat_reg & irq_en_reg);
    assign print_cmd_out = print_cmd_reg;
    assign pad_lower_out = pad_lower_reg;

    // Contacts toward the controller, all sensed against one common return
    apph_contact u_prn_fault (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .active(printer_error_in),
        .closed(printer_fault_out)
    );
    apph_contact u_job_absent (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .active(!job_available_in),
        .closed(job_absent_out)
    );
    apph_contact u_any_fault (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .active(printer_error_in || applicator_error_in),
        .closed(any_fault_out)
    );
    apph_contact u_app_fault (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .active(applicator_error_in),
        .closed(applicator_fault_out)
    );
    apph_contact u_pad_home (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .active(pad_at_home_in),
        .closed(pad_home_out)
    );
    // Reset value is the opposite of the plain copy so the pair never agrees
    apph_contact #(
        .CLOSED_AT_RESET(1'b0)
    ) u_pad_home_n (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .active(!pad_at_home_in),
        .closed(pad_home_n_out)
    );
    apph_contact u_pad_down (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .active(pad_at_label_in),
        .closed(pad_down_out)
    );

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence fault_seen_s;
        state_reg == APPH_ST_PRINT && printer_error_in;
    endsequence
    sequence fault_cleared_s;
        state_reg == APPH_ST_FAULT && !printer_error_in;
    endsequence

    start_begin_a: assert property (
        state_reg == APPH_ST_IDLE && start_rise && !blocked
        |=> state_reg == APPH_ST_PRINT ##0 print_cmd_out)
        else $error("start request did not begin a cycle");

    stop_finish_a: assert property (
        state_reg == APPH_ST_PRINT && blocked && !printer_error_in && label_picked_in
        |=> state_reg == APPH_ST_IDLE)
        else $error("stopped print did not end after pickup");

    stop_abort_a: assert property (
        state_reg == APPH_ST_LOWER && stop_db |=> state_reg == APPH_ST_RAISE)
        else $error("stop did not abort the application");

    pad_return_a: assert property (
        stop_latched_reg |-> !pad_lower_out)
        else $error("pad still lowered while stopped");

    start_ignore_a: assert property (
        stop_latched_reg && start_rise && state_reg != APPH_ST_FAULT
        |=> !print_cmd_out && !pad_lower_out)
        else $error("start accepted after stop");

    host_err_a: assert property (
        state_reg == APPH_ST_LOWER && new_stop |=> host_err_reg && stop_latched_reg)
        else $error("stop during application gave no host-stop error");

    print_no_err_a: assert property (
        state_reg == APPH_ST_PRINT && new_stop && !host_err_reg |=> !host_err_reg)
        else $error("stop during printing raised host-stop error");

    first_mode_a: assert property (
        state_reg == APPH_ST_IDLE && first_rise && !mode_reg && !start_rise
        |=> state_reg == APPH_ST_IDLE)
        else $error("first-label request acted outside apply-after-print");

    fault_enter_a: assert property (
        fault_seen_s |=> state_reg == APPH_ST_FAULT && !print_cmd_out)
        else $error("printer error did not halt the print");

    reprint_a: assert property (
        fault_cleared_s |=> state_reg == APPH_ST_PRINT && print_cmd_out)
        else $error("label not reprinted after printer error");

    print_pulse_a: assert property (
        print_cmd_out |=> !print_cmd_out)
        else $error("print command longer than one cycle");

    job_absent_a: assert property (
        !job_available_in [*2] |-> !job_absent_out)
        else $error("job-absent contact closed with no job");

    home_pair_a: assert property (
        pad_home_out != pad_home_n_out)
        else $error("pad-home pair not complementary");

    any_fault_a: assert property (
        !printer_fault_out || !applicator_fault_out |-> !any_fault_out)
        else $error("general fault contact closed during a fault");

    bus_answer_a: assert property (
        access && !ack_reg |=> !avs_waitrequest || !access)
        else $error("bus access not answered in one wait cycle");

endmodule

// [verif/apph_mech_model.sv]
`timescale 1ns/1ps
// Printer and pad mechanics on the far side; slow modes stretch each move
module apph_mech_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic print_cmd_out,
    input wire logic pad_lower_out,
    input wire logic slow_print,
    input wire logic slow_pad,
    output logic label_picked_in,
    output logic pad_at_home_in,
    output logic pad_at_label_in
);
    logic [8:0] pc;
    logic [8:0] mc;
    logic low_d;
    // Label reaches the pad some time after each print command
    // Pad leaves both end sensors while moving, so no stale position shows
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            {label_picked_in, pad_at_label_in, low_d} <= 3'h0;
            pad_at_home_in <= 1'b1;
            pc <= 9'h000;
            mc <= 9'h000;
        end else begin
            low_d <= pad_lower_out;
            if (print_cmd_out) begin
                pc <= slow_print ? 9'h12c : 9'h008;
            end else if (pc != 9'h000) begin
                pc <= pc - 9'h001;
            end
            // One-cycle pickup pulse, so an old label never reads as a fresh one
            label_picked_in <= !print_cmd_out && (pc == 9'h001);
            if (pad_lower_out != low_d) begin
                {pad_at_home_in, pad_at_label_in} <= 2'h0;
                mc <= slow_pad ? 9'h12c : 9'h006;
            end else if (mc == 9'h001) begin
                mc <= 9'h000;
                pad_at_label_in <= low_d;
                pad_at_home_in <= !low_d;
            end else if (mc != 9'h000) begin
                mc <= mc - 9'h001;
            end
        end
    end
endmodule

// [verif/tb_applicator_plc_handshake.sv]
`timescale 1ns/1ps
module tb_applicator_plc_handshake;
    import apph_pkg::*;
    logic ref_clk, rstn, avs_read, avs_write, avs_waitrequest, irq;
    logic [2:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, r, seed;
    logic [3:0] avs_byteenable;
    logic start_request_in, stop_request_in, first_label_request_in, printer_error_in;
    logic job_available_in, label_picked_in, pad_at_home_in, pad_at_label_in;
    logic applicator_error_in, print_cmd_out, pad_lower_out, printer_fault_out;
    logic job_absent_out, any_fault_out, pad_home_out, pad_home_n_out, pad_down_out;
    logic applicator_fault_out, slow_print, slow_pad, on, rnd, plow_q;
    logic pe_d, ae_d, ja_d, ph_d, pl_d;
    logic [31:0] eq[$];
    logic [31:0] mq[$];
    int num_errors = 0, n_tests = 0, prints = 0, lowers = 0, p0, l0;

    apph_top dut_u (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .start_request_in,
        .stop_request_in, .first_label_request_in, .printer_error_in, .job_available_in,
        .label_picked_in, .pad_at_home_in, .pad_at_label_in, .applicator_error_in,
        .print_cmd_out, .pad_lower_out, .printer_fault_out, .job_absent_out, .any_fault_out,
        .pad_home_out, .pad_home_n_out, .pad_down_out, .applicator_fault_out);
    apph_mech_model mech_u (.ref_clk, .rstn, .print_cmd_out, .pad_lower_out, .slow_print,
        .slow_pad, .label_picked_in, .pad_at_home_in, .pad_at_label_in);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    // Master holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
        eq.push_back(e);
        mq.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic irq_is(input logic e);
        @(negedge ref_clk);
        check("irq", irq, e);
        @(posedge ref_clk);
    endtask
    // Lines are held well past the input filter time, high meaning voltage applied
    task automatic start_cycle;
        start_request_in <= 1'b1;
        wt(120);
        start_request_in <= 1'b0;
        wt(120);
    endtask
    task automatic first_cycle;
        first_label_request_in <= 1'b1;
        wt(120);
        first_label_request_in <= 1'b0;
        wt(120);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Delayed inputs for the contact monitor; job line goes random when asked
    always @(posedge ref_clk) begin
        pe_d <= printer_error_in;
        ae_d <= applicator_error_in;
        ja_d <= job_available_in;
        ph_d <= pad_at_home_in;
        pl_d <= pad_at_label_in;
        seed <= !rstn ? 32'h71b3fcc2 : lfsr(seed);
        job_available_in <= rnd ? seed[0] : 1'b1;
    end
    // Outputs looked at mid-cycle, where everything launched at the edge has settled
    always @(negedge ref_clk) begin
        if (print_cmd_out === 1'b1) prints++;
        if (pad_lower_out === 1'b1 && plow_q !== 1'b1) lowers++;
        plow_q = pad_lower_out;
        if (avs_read && avs_waitrequest === 1'b0) begin
            check("readdata", avs_readdata & mq[0], eq[0]);
            void'(eq.pop_front());
            void'(mq.pop_front());
        end
        // Every contact is judged against the one shared return: 0 is open
        if (on) begin
            check("printer_fault", printer_fault_out, !pe_d);
            check("job_absent", job_absent_out, ja_d);
            check("any_fault", any_fault_out, !(pe_d | ae_d));
            check("applicator_fault", applicator_fault_out, !ae_d);
            check("pad_home", pad_home_out, !ph_d);
            check("pad_home_n", pad_home_n_out, ph_d);
            check("pad_down", pad_down_out, !pl_d);
        end
    end
    initial begin
        wt(30000);
        num_errors++;
        tally_and_finish;
    end

    initial begin
        rstn = 1'b0;
        {avs_read, avs_write, start_request_in, stop_request_in, first_label_request_in} = '0;
        {printer_error_in, applicator_error_in, slow_print, slow_pad, on, rnd} = '0;
        avs_address = 3'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        wt(5);
        rstn <= 1'b1;
        wt(3);
        on <= 1'b1;
        // Reset values, unmapped index, enable register round trip
        rd(APPH_CTRL_IDX, 32'h0, 32'h3);
        rd(APPH_STATUS_IDX, 32'h0, 32'h1f);
        rd(APPH_IRQ_EN_IDX, 32'h0, 32'h1f);
        rd(3'h7, 32'h0, 32'hffffffff);
        r = seed;
        bus(1'b1, APPH_IRQ_EN_IDX, r);
        rd(APPH_IRQ_EN_IDX, {27'h0, r[4:0]}, 32'h1f);
        // A write without lane 0 must leave the register alone
        avs_byteenable <= 4'he;
        bus(1'b1, APPH_IRQ_EN_IDX, 32'h0);
        avs_byteenable <= 4'hf;
        rd(APPH_IRQ_EN_IDX, {27'h0, r[4:0]}, 32'h1f);
        bus(1'b1, APPH_IRQ_EN_IDX, 32'h1f);
        // Plain cycle raises start and done, then clear and mask
        p0 = prints;
        start_cycle();
        check("prints", prints, p0 + 1);
        rd(APPH_IRQ_STAT_IDX, 32'h11, 32'h1f);
        irq_is(1'b1);
        bus(1'b1, APPH_IRQ_CLR_IDX, 32'h1f);
        irq_is(1'b0);
        bus(1'b1, APPH_IRQ_EN_IDX, 32'h0);
        start_cycle();
        rd(APPH_IRQ_STAT_IDX, 32'h11, 32'h1f);
        irq_is(1'b0);
        bus(1'b1, APPH_IRQ_EN_IDX, 32'h1f);
        // Fault and job lines while idle
        applicator_error_in <= 1'b1;
        printer_error_in <= 1'b1;
        wt(4);
        applicator_error_in <= 1'b0;
        wt(3);
        printer_error_in <= 1'b0;
        rnd <= 1'b1;
        wt(200);
        rnd <= 1'b0;
        wt(2);
        bus(1'b1, APPH_IRQ_CLR_IDX, 32'h1f);
        // Stop while the pad is going down
        slow_pad <= 1'b1;
        start_request_in <= 1'b1;
        do @(negedge ref_clk); while (pad_lower_out !== 1'b1);
        @(posedge ref_clk);
        stop_request_in <= 1'b1;
        wt(120);
        check("pad_lower", pad_lower_out, 1'b0);
        rd(APPH_STATUS_IDX, 32'h18, 32'h18);
        p0 = prints;
        start_request_in <= 1'b0;
        wt(120);
        start_cycle();
        check("prints", prints, p0);
        stop_request_in <= 1'b0;
        wt(420);
        bus(1'b1, APPH_CTRL_IDX, 32'h2);
        rd(APPH_STATUS_IDX, 32'h0, 32'h1f);
        // Stop while printing: label finishes, no labelling, no host error
        slow_pad <= 1'b0;
        slow_print <= 1'b1;
        p0 = prints;
        l0 = lowers;
        start_request_in <= 1'b1;
        wt(120);
        stop_request_in <= 1'b1;
        wt(350);
        check("prints", prints, p0 + 1);
        check("lowers", lowers, l0);
        rd(APPH_STATUS_IDX, 32'h08, 32'h1f);
        {start_request_in, stop_request_in} <= 2'h0;
        wt(120);
        bus(1'b1, APPH_CTRL_IDX, 32'h2);
        // Printer error in mid-print, then reprint once cleared
        p0 = prints;
        start_request_in <= 1'b1;
        wt(120);
        printer_error_in <= 1'b1;
        wt(10);
        rd(APPH_IRQ_STAT_IDX, 32'h08, 32'h08);
        printer_error_in <= 1'b0;
        wt(20);
        check("prints", prints, p0 + 2);
        start_request_in <= 1'b0;
        slow_print <= 1'b0;
        wt(400);
        // First-label request only in apply-after-print mode
        p0 = prints;
        first_cycle();
        check("prints", prints, p0);
        bus(1'b1, APPH_CTRL_IDX, 32'h1);
        first_cycle();
        check("prints", prints, p0 + 1);
        rd(APPH_STATUS_IDX, 32'h3, 32'h7);
        l0 = lowers;
        start_cycle();
        check("lowers", lowers, l0 + 1);
        check("prints", prints, p0 + 2);
        rd(APPH_STATUS_IDX, 32'h3, 32'h7);
        tally_and_finish;
    end
endmodule
